// File: core/acc_pkg.sv
package acc_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses, one word each)
    // ----------------------------------------------------------------
    localparam int unsigned ACC_AW          = 5;
    localparam logic [4:0]  ACC_OFF_CTRL_A  = 5'h00;
    localparam logic [4:0]  ACC_OFF_CTRL_B  = 5'h04;
    localparam logic [4:0]  ACC_OFF_CHSEL   = 5'h08;
    localparam logic [4:0]  ACC_OFF_RES_LO  = 5'h0c;
    localparam logic [4:0]  ACC_OFF_RES_HI  = 5'h10;
    localparam logic [4:0]  ACC_OFF_PWR     = 5'h14;

    // converter_control_reg_a fields
    localparam int unsigned ACC_EN_BIT      = 0;
    localparam int unsigned ACC_START_BIT   = 1;
    localparam int unsigned ACC_AUTO_BIT    = 2;
    localparam int unsigned ACC_DONE_BIT    = 3;
    localparam int unsigned ACC_PRESC_LSB   = 4;
    // converter_control_reg_b fields
    localparam int unsigned ACC_TSEL_LSB    = 0;
    // channel_reference_select_reg fields
    localparam int unsigned ACC_CHAN_LSB    = 0;
    localparam int unsigned ACC_LEFT_BIT    = 5;
    localparam int unsigned ACC_REF_LSB     = 6;
    // power register field
    localparam int unsigned ACC_PR_BIT      = 0;

    // reset values
    localparam logic        ACC_PR_RESET    = 1'b0;
    localparam logic [2:0]  ACC_PRESC_RESET = 3'h0;

    // ----------------------------------------------------------------
    // conversion timing, in converter clock cycles
    // ----------------------------------------------------------------
    localparam logic [4:0]  ACC_LEN_NORMAL  = 5'h0d;  // 13
    localparam logic [4:0]  ACC_LEN_FIRST   = 5'h19;  // 25
    localparam logic [4:0]  ACC_SH_NORMAL   = 5'h01;  // falling edge of cycle 1 -> 1.5
    localparam logic [4:0]  ACC_SH_FIRST    = 5'h0d;  // falling edge of cycle 13 -> 13.5
    localparam logic [4:0]  ACC_SH_AUTO     = 5'h01;  // rising edge ending cycle 1 -> 2
    localparam logic [2:0]  ACC_TSEL_FREE   = 3'h0;   // source 0 is the done flag
    localparam int unsigned ACC_TRIG_W      = 8;

    typedef enum logic [2:0] {
        ACC_IDLE = 3'b001,
        ACC_WAIT = 3'b010,
        ACC_CONV = 3'b100
    } acc_fsm_t;

    // controls and status toward the analog core
    typedef struct packed {
        logic       enable;
        logic [3:0] channel_select;
        logic [1:0] reference_select;
        logic       sample;
        logic       converting;
        logic       adc_tick;
    } acc_ana_t;

    // whole state of the control block
    typedef struct packed {
        logic       converter_enable;
        logic       start_conversion;
        logic       auto_trigger_enable;
        logic       conversion_done_flag;
        logic [2:0] clock_prescale_select;
        logic [2:0] trigger_source_select;
        logic [3:0] channel_select;
        logic [1:0] reference_select;
        logic       result_left_align;
        logic       converter_power_reduction;
        logic [3:0] chan_buf;
        logic [1:0] ref_buf;
        logic [7:0] result_low_byte;
        logic [7:0] result_high_byte;
        logic       lock;
        logic       first;
        logic       trig_mode;
        logic [4:0] cyc;
        acc_fsm_t   fsm;
        logic       trig_prev;
        logic [31:0] rdata;
        logic       slverr;
    } acc_st_t;

endpackage : acc_pkg

// File: core/acc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module acc_sync #(
    parameter int W = 8
) (
    input  wire logic         clk_sys,
    input  wire logic         nrst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] hold;
    } acc_sync_st_t;

    acc_sync_st_t s;
    acc_sync_st_t next_s;

    // two flops per bit; only the second stage leaves the module
    always_comb begin
        next_s      = s;
        next_s.meta = d;
        next_s.hold = s.meta;
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign q = s.hold;
endmodule : acc_sync
`default_nettype wire

// File: core/acc_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module acc_prescaler (
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    input  wire logic       run,
    input  wire logic       restart,
    input  wire logic [2:0] sel,
    output logic            rise,
    output logic            fall
);
    typedef struct packed {
        logic [6:0] cnt;
    } acc_psc_st_t;

    acc_psc_st_t s;
    acc_psc_st_t next_s;
    logic [7:0]  div;

    // divide by 2 for settings 0 and 1, else by 2^sel; 128 needs the eighth bit
    assign div  = (sel == 3'h0) ? 8'h02 : 8'h01 << sel;
    assign rise = run && (s.cnt == 7'(div - 8'h01));
    assign fall = run && (s.cnt == 7'((div >> 1) - 8'h01));

    // held at zero while stopped; restart realigns the phase to a trigger
    always_comb begin
        next_s = s;
        if (!run || restart) begin
            next_s.cnt = 7'h00;
        end else if (rise) begin
            next_s.cnt = 7'h00;
        end else begin
            next_s.cnt = s.cnt + 7'h01;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule : acc_prescaler
`default_nettype wire

// File: core/acc_top.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE1: result goes right-aligned in the two bytes, left-aligned when left-align is set.
// RULE2: reading the low byte blocks converter writes to both result bytes.
// RULE3: a conversion finishing while blocked is discarded, bytes unchanged.
// RULE4: reading the high byte unblocks result writes.
// RULE5: done flag sets after every conversion, discarded ones too.
// RULE6: writing start begins one conversion; start stays set, hardware clears it.
// RULE7: channel written mid-conversion waits for the next conversion.
// RULE8: with auto-trigger, a trigger rising edge resets the prescaler and starts.
// RULE9: edges during a conversion are ignored; a level left high restarts nothing.
// RULE10: software must clear a trigger flag before its next event counts.
// RULE11: done-flag source runs free regardless of the flag; first start is software.
// RULE12: start still works with auto-trigger; start reads one during any conversion.
// RULE13: prescaler runs while enabled and is held reset while disabled.
// RULE14: channel and reference reach the analog core only once enabled.
// RULE15: software keeps the converter clock between 50kHz and 200kHz for 10 bits.
// RULE16: a software start begins at the next rising converter clock edge.
// RULE17: normal conversion 13 converter cycles, first after enable 25.
// RULE18: sample-and-hold 1.5 cycles in, or 13.5 for the first conversion.
// RULE19: completion writes result, sets done flag, clears start in single mode.
// RULE20: auto-trigger samples two cycles after the edge plus three sync clocks.
// RULE21: free running restarts at once after completion, start stays set.
// RULE22: software clears power reduction before enabling or starting.
// RULE23: selection buffer frozen during conversion, follows writes in last cycle.
module acc_top
    import acc_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic                  nrst,

    // register bus
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ACC_AW-1:0]     paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,

    // triggers
    input  wire logic [ACC_TRIG_W-1:0] trig_in,

    // analog core
    input  wire logic [9:0]            ana_result,
    output acc_ana_t                   ana,
    output logic                       conversion_done_flag
);

    // ----------------------------------------------------------------
    // state and helper nets
    // ----------------------------------------------------------------
    acc_st_t               s;
    acc_st_t               next_s;
    logic [ACC_TRIG_W-1:0] trig_s;

    // prescaler strobes
    logic                  rise;
    logic                  fall;
    logic                  presc_restart;
    logic                  sample;

    // bus decode
    logic                  wr;
    logic                  rd;
    logic                  setup;

    // sequencer
    logic                  trig_now;
    logic                  trig_edge;
    logic                  free_run;
    logic                  complete;
    logic                  frozen;
    logic [4:0]            last;
    logic [4:0]            sh_cyc;

    // ----------------------------------------------------------------
    // trigger inputs come from other logic or pins: two flops each
    // ----------------------------------------------------------------
    acc_sync #(
        .W (ACC_TRIG_W)
    ) u_sync (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .d       (trig_in),
        .q       (trig_s)
    );

    // ----------------------------------------------------------------
    // converter clock
    // ----------------------------------------------------------------
    acc_prescaler u_presc (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .run     (s.converter_enable),      // [RULE13]
        .restart (presc_restart),           // [RULE8]
        .sel     (s.clock_prescale_select),
        .rise    (rise),
        .fall    (fall)
    );

    // ----------------------------------------------------------------
    // decoded conditions
    // ----------------------------------------------------------------
    // apb phases; pready is always high so every access phase is one cycle
    assign setup = psel && !penable;
    assign wr    = psel && penable && pwrite;
    assign rd    = psel && penable && !pwrite;

    // synchroniser plus the sequencer state flop make the three extra clocks; the edge term itself is combinational
    assign trig_now  = trig_s[s.trigger_source_select];
    assign trig_edge = trig_now && !s.trig_prev;          // [RULE20]

    assign free_run = s.auto_trigger_enable && (s.trigger_source_select == ACC_TSEL_FREE);

    // cycle bookkeeping
    assign last     = (s.first ? ACC_LEN_FIRST : ACC_LEN_NORMAL) - 5'h01;   // [RULE17]
    assign sh_cyc   = s.trig_mode ? ACC_SH_AUTO : (s.first ? ACC_SH_FIRST : ACC_SH_NORMAL);

    assign complete = (s.fsm == ACC_CONV) && rise && (s.cyc == last);
    assign frozen   = (s.fsm == ACC_CONV) && (s.cyc != last);                // [RULE23]

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        next_s        = s;
        presc_restart = 1'b0;
        sample        = 1'b0;

        // register writes
        if (wr) begin
            unique case (paddr)
                ACC_OFF_CTRL_A: begin
                    // power reduction keeps the converter off
                    next_s.converter_enable      = pwdata[ACC_EN_BIT] && !s.converter_power_reduction;
                    next_s.auto_trigger_enable   = pwdata[ACC_AUTO_BIT];
                    next_s.clock_prescale_select = pwdata[ACC_PRESC_LSB +: 3];

                    if (pwdata[ACC_START_BIT] && next_s.converter_enable) begin
                        next_s.start_conversion = 1'b1;             // [RULE6] [RULE12]
                    end

                    if (pwdata[ACC_DONE_BIT]) begin
                        next_s.conversion_done_flag = 1'b0;         // write one clears
                    end
                end

                ACC_OFF_CTRL_B: begin
                    next_s.trigger_source_select = pwdata[ACC_TSEL_LSB +: 3];
                end

                ACC_OFF_CHSEL: begin
                    next_s.channel_select    = pwdata[ACC_CHAN_LSB +: 4];
                    next_s.result_left_align = pwdata[ACC_LEFT_BIT];
                    next_s.reference_select  = pwdata[ACC_REF_LSB +: 2];
                end

                ACC_OFF_PWR: begin
                    next_s.converter_power_reduction = pwdata[ACC_PR_BIT];

                    if (pwdata[ACC_PR_BIT]) begin
                        next_s.converter_enable = 1'b0;
                    end
                end

                default: begin
                end
            endcase
        end

        // read side effects on the result bytes
        if (rd && (paddr == ACC_OFF_RES_LO)) begin
            next_s.lock = 1'b1;                                     // [RULE2]
        end

        if (rd && (paddr == ACC_OFF_RES_HI)) begin
            next_s.lock = 1'b0;                                     // [RULE4]
        end

        // edge detector follows the level always, so a held level is no edge
        next_s.trig_prev = trig_now;                                // [RULE9]

        // conversion sequencer
        unique case (s.fsm)
            ACC_IDLE: begin
                // software start waits for a tick
                if (s.start_conversion) begin
                    next_s.fsm = ACC_WAIT;
                end else if (s.auto_trigger_enable && !free_run && trig_edge) begin
                    next_s.fsm              = ACC_CONV;             // [RULE8]
                    next_s.cyc              = 5'h00;
                    next_s.trig_mode        = 1'b1;
                    next_s.start_conversion = 1'b1;                 // [RULE12]
                    presc_restart           = 1'b1;
                end
            end

            ACC_WAIT: begin
                if (rise) begin
                    next_s.fsm       = ACC_CONV;                    // [RULE16]
                    next_s.cyc       = 5'h00;
                    next_s.trig_mode = 1'b0;
                end
            end

            ACC_CONV: begin
                // edges here fall through unused                    [RULE9]
                if (s.trig_mode) begin
                    sample = rise && (s.cyc == sh_cyc);             // [RULE20]
                end else begin
                    sample = fall && (s.cyc == sh_cyc);             // [RULE18]
                end

                if (complete) begin
                    next_s.conversion_done_flag = 1'b1;             // [RULE5] [RULE19]
                    next_s.first                = 1'b0;

                    if (!s.lock) begin                              // [RULE3]
                        if (s.result_left_align) begin
                            next_s.result_high_byte = ana_result[9:2];            // [RULE1]
                            next_s.result_low_byte  = {ana_result[1:0], 6'h00};
                        end else begin
                            next_s.result_high_byte = {6'h00, ana_result[9:8]};   // [RULE1]
                            next_s.result_low_byte  = ana_result[7:0];
                        end
                    end

                    if (free_run) begin
                        next_s.cyc       = 5'h00;                   // [RULE11] [RULE21]
                        next_s.trig_mode = 1'b0;
                    end else begin
                        next_s.fsm              = ACC_IDLE;
                        next_s.start_conversion = 1'b0;             // [RULE6] [RULE19]
                    end
                end else if (rise) begin
                    next_s.cyc = s.cyc + 5'h01;                     // [RULE17]
                end
            end

            default: begin
                next_s.fsm = ACC_IDLE;
            end
        endcase

        // selection buffer tracks software only while enabled and unfrozen
        if (s.converter_enable && !frozen) begin
            next_s.chan_buf = s.channel_select;                     // [RULE7] [RULE14] [RULE23]
            next_s.ref_buf  = s.reference_select;
        end

        // disabling aborts everything and re-arms the long first conversion
        if (!next_s.converter_enable) begin
            next_s.fsm              = ACC_IDLE;
            next_s.start_conversion = 1'b0;
            next_s.first            = 1'b1;                         // [RULE17]
            next_s.cyc              = 5'h00;
        end

        // read data captured in setup so prdata leaves a flop
        next_s.slverr = 1'b0;

        if (setup) begin
            next_s.rdata = 32'h0000_0000;
            unique case (paddr)
                ACC_OFF_CTRL_A: begin
                    next_s.rdata[ACC_EN_BIT]          = s.converter_enable;
                    next_s.rdata[ACC_START_BIT]       = s.start_conversion || (s.fsm != ACC_IDLE);
                    next_s.rdata[ACC_AUTO_BIT]        = s.auto_trigger_enable;
                    next_s.rdata[ACC_DONE_BIT]        = s.conversion_done_flag;
                    next_s.rdata[ACC_PRESC_LSB +: 3]  = s.clock_prescale_select;
                end

                ACC_OFF_CTRL_B: begin
                    next_s.rdata[ACC_TSEL_LSB +: 3]   = s.trigger_source_select;
                end

                ACC_OFF_CHSEL: begin
                    next_s.rdata[ACC_CHAN_LSB +: 4]   = s.channel_select;
                    next_s.rdata[ACC_LEFT_BIT]        = s.result_left_align;
                    next_s.rdata[ACC_REF_LSB +: 2]    = s.reference_select;
                end

                ACC_OFF_RES_LO: begin
                    next_s.rdata[7:0]                 = s.result_low_byte;
                end

                ACC_OFF_RES_HI: begin
                    next_s.rdata[7:0]                 = s.result_high_byte;
                end

                ACC_OFF_PWR: begin
                    next_s.rdata[ACC_PR_BIT]          = s.converter_power_reduction;
                end

                default: begin
                    next_s.slverr = 1'b1;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    // idle and long first conversion out of reset
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            s                           <= '0;

            s.fsm                       <= ACC_IDLE;
            s.first                     <= 1'b1;
            s.converter_power_reduction <= ACC_PR_RESET;
            s.clock_prescale_select     <= ACC_PRESC_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign prdata               = s.rdata;
    assign pready               = 1'b1;

    assign pslverr              = s.slverr && psel && penable;

    assign conversion_done_flag = s.conversion_done_flag;

    // the buffer only loads once enabled, so the core sees the previous pick for the first clock after enable
    assign ana.enable           = s.converter_enable;
    assign ana.channel_select   = s.chan_buf;
    assign ana.reference_select = s.ref_buf;

    assign ana.sample           = sample;
    assign ana.converting       = (s.fsm == ACC_CONV);
    assign ana.adc_tick         = rise;

endmodule : acc_top
`default_nettype wire

// File: tb/acc_chk.sv
`timescale 1ns/1ps
`default_nettype none
module acc_chk
    import acc_pkg::*;
(
    input wire logic                  clk_sys,
    input wire logic                  nrst,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [ACC_AW-1:0]     paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic [ACC_TRIG_W-1:0] trig_in,
    input wire logic [9:0]            ana_result,
    input wire acc_ana_t              ana,
    input wire logic                  conversion_done_flag
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // ------------------------------------------------------------
    // bus side
    // ------------------------------------------------------------
    err_gate_a: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access phase");
    unmapped_err_a: assert property (psel && penable && paddr > ACC_OFF_PWR |-> pslverr)
        else $error("unmapped access without error");
    busy_read_a: assert property (psel && penable && !pwrite && paddr == ACC_OFF_CTRL_A
        && $past(ana.converting) |-> prdata[ACC_START_BIT]) else $error("start reads zero mid conversion");
    // ------------------------------------------------------------
    // converter side
    // ------------------------------------------------------------
    tick_off_a: assert property (!ana.enable |-> !ana.adc_tick && !ana.converting)
        else $error("converter active while disabled");
    sel_hold_a: assert property (!ana.enable |=> $stable(ana.channel_select)
        && $stable(ana.reference_select)) else $error("selection moved while disabled");
    sample_conv_a: assert property (ana.sample |-> ana.converting)
        else $error("sample outside conversion");
    sample_pulse_a: assert property (ana.sample |=> !ana.sample) else $error("sample wider than one clock");
    tick_pulse_a: assert property (ana.adc_tick |=> !ana.adc_tick) else $error("tick wider than one clock");
    done_src_a: assert property ($rose(conversion_done_flag) |-> $past(ana.converting))
        else $error("done flag without conversion");
endmodule : acc_chk
bind acc_top acc_chk u_chk (.clk_sys, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .trig_in, .ana_result, .ana, .conversion_done_flag);
`default_nettype wire

// File: tb/acc_ana_model.sv
`timescale 1ns/1ps
`default_nettype none
module acc_ana_model
    import acc_pkg::*;
(
    input  wire logic     clk_sys,
    input  wire acc_ana_t ana,
    output logic [9:0]    ana_result
);
    logic [9:0] held;
    initial held = 10'h000;
    // the code encodes the selection seen at the hold instant
    always @(posedge clk_sys) begin
        if (ana.sample) begin
            held <= {ana.channel_select, ana.reference_select, 4'h9};
        end
    end
    // outside a conversion the output is junk, so a late capture shows up
    assign ana_result = ana.converting ? held : ~held;
endmodule : acc_ana_model
`default_nettype wire

// File: tb/acc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module acc_top_tb;
    import acc_pkg::*;
    logic clk_sys, nrst, psel, penable, pwrite, pready, pslverr, conversion_done_flag, rerr;
    logic [4:0] paddr;
    logic [31:0] pwdata, prdata, rdq;
    logic [7:0] trig_in;
    logic [9:0] ana_result;
    acc_ana_t ana;
    int errors = 0, checks_done = 0, cycles = 0, cnt = 0, sh_at = 0, len_at = 0;
    acc_top dut (.clk_sys, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .trig_in, .ana_result, .ana, .conversion_done_flag);
    acc_ana_model u_ana (.clk_sys, .ana, .ana_result);
    // ------------------------------------------------------------
    // clock, timeout and conversion monitor
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // ticks counted from conversion start locate hold and end
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            print_verdict();
        end
        if (!ana.converting) cnt <= 0;
        else if (ana.adc_tick) begin
            cnt <= cnt + 1;
            len_at <= cnt + 1;
        end
        if (ana.sample) sh_at <= cnt;
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [4:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rdq = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic rd(input logic [4:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rdq);
    endtask : rd
    task automatic wait_done();
        while (conversion_done_flag !== 1'b1) @(posedge clk_sys);
    endtask : wait_done
    // expected result bytes {high, low}, in the model's encoding
    function automatic logic [31:0] res(input logic [3:0] ch, input logic left);
        logic [9:0] v;
        v = {ch, 2'b00, 4'h9};
        return left ? {16'h0, v[9:2], v[1:0], 6'h0} : {16'h0, 6'h0, v};
    endfunction : res
    task automatic rd_res(input logic [31:0] e);
        rd(ACC_OFF_RES_LO, {24'h0, e[7:0]}, "result low");
        rd(ACC_OFF_RES_HI, {24'h0, e[15:8]}, "result high");
    endtask : rd_res
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {nrst, psel, penable, pwrite, paddr, pwdata, trig_in} = '0;
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        rd(ACC_OFF_CTRL_A, 32'h0, "ctrl a reset");
        rd(ACC_OFF_PWR, 32'h0, "pwr reset");
        apb(1'b0, 5'h18, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, rerr});
        apb(1'b1, ACC_OFF_PWR, 32'h1);
        apb(1'b1, ACC_OFF_CTRL_A, 32'h1);
        rd(ACC_OFF_CTRL_A, 32'h0, "enable under power off");
        apb(1'b1, ACC_OFF_PWR, 32'h0);
        apb(1'b1, ACC_OFF_CHSEL, 32'h3);
        apb(1'b1, ACC_OFF_CTRL_A, 32'h3);
        rd(ACC_OFF_CTRL_A, 32'h3, "start held");
        wait_done();
        @(posedge clk_sys);
        chk("first length", 32'd25, len_at);
        chk("first hold", 32'd13, sh_at);
        rd(ACC_OFF_CTRL_A, 32'h9, "start cleared");
        rd_res(res(4'h3, 1'b0));
        apb(1'b1, ACC_OFF_CTRL_A, 32'hb);
        apb(1'b1, ACC_OFF_CHSEL, 32'h5);
        wait_done();
        @(posedge clk_sys);
        chk("normal length", 32'd13, len_at);
        chk("normal hold", 32'd1, sh_at);
        rd_res(res(4'h3, 1'b0));
        // low read locks, the next result is lost but still flagged
        rd(ACC_OFF_RES_LO, {24'h0, res(4'h3, 1'b0)}, "lock low");
        apb(1'b1, ACC_OFF_CHSEL, 32'h25);
        apb(1'b1, ACC_OFF_CTRL_A, 32'hb);
        wait_done();
        rd(ACC_OFF_RES_HI, {24'h0, res(4'h3, 1'b0) >> 8}, "locked high");
        apb(1'b1, ACC_OFF_CTRL_A, 32'hb);
        wait_done();
        rd_res(res(4'h5, 1'b1));
        // auto trigger on source 1, edge inside conversion, level left high
        apb(1'b1, ACC_OFF_CTRL_B, 32'h1);
        apb(1'b1, ACC_OFF_CTRL_A, 32'hd);
        trig_in <= 8'h02;
        repeat (10) @(posedge clk_sys);
        trig_in <= 8'h00;
        repeat (2) @(posedge clk_sys);
        trig_in <= 8'h02;
        wait_done();
        apb(1'b1, ACC_OFF_CTRL_A, 32'hd);
        repeat (80) @(posedge clk_sys);
        chk("no retrigger", 32'h0, {31'h0, conversion_done_flag});
        trig_in <= 8'h00;
        // free running on the done flag
        apb(1'b1, ACC_OFF_CTRL_B, 32'h0);
        apb(1'b1, ACC_OFF_CTRL_A, 32'hf);
        wait_done();
        rd(ACC_OFF_CTRL_A, 32'hf, "free run start");
        apb(1'b1, ACC_OFF_CTRL_A, 32'hd);
        wait_done();
        rd(ACC_OFF_CTRL_A, 32'hf, "free run again");
        apb(1'b1, ACC_OFF_CTRL_A, 32'h0);
        print_verdict();
    end
endmodule : acc_top_tb
`default_nettype wire
